// *** alarm_pkg.sv ***
/*
  Package for the alarm status aggregator: register offsets, flag positions,
  reset values and the register access struct.
  Assumes a register port that presents one decoded access per cycle.
*/
package alarm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ALARM_SUMMARY_ADDR = 12'h2C0;
  localparam logic [11:0] ALARM_FLAGS_ADDR = 12'h2C1;
  localparam logic [11:0] ALARM_MASKS_ADDR = 12'h2C2;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int NUM_ALARMS = 5;
  localparam int SUMMARY_BIT = 0;
  localparam int PLL_UNLOCK_BIT = 4;
  localparam int LINK_DOWN_BIT = 3;
  localparam int CLOCK_REALIGN_BIT = 2;
  localparam int OSC_PHASE_BIT = 1;
  localparam int DIVIDER_MISMATCH_BIT = 0;
  localparam logic [4:0] FLAGS_RESET = 5'h1F;
  localparam logic [4:0] MASKS_RESET = 5'h1F;

  // ----------------------------------------
  // Register access carrier
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Raw alarm conditions from the rest of the device
  typedef struct packed {
    logic pll_locked;
    logic link_enable;
    logic data_transmission_state;
    logic sysref_realign;
    logic osc_sync;
    logic phase_acc_mismatch;
    logic divider_mismatch;
  } alarm_cond_t;

endpackage : alarm_pkg

// *** alarm_regfile.sv ***
/*
  Register store for the alarm flags and masks.
  Assumes conditions are synchronous to clk_in and already decoded to flag bits.
*/
`timescale 1ns/100ps
module alarm_regfile #(
  parameter int WIDTH = alarm_pkg::NUM_ALARMS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic flags_wr_in,
  input wire logic masks_wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] flags_out,
  output logic [WIDTH-1:0] masks_out
);

  logic [WIDTH-1:0] flags_r, flags_nxt;
  logic [WIDTH-1:0] masks_r, masks_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    masks_nxt = masks_r;
    if (flags_wr_in) begin
      flags_nxt = flags_r & ~wdata_in;
    end
    flags_nxt = flags_nxt | set_in;
    if (masks_wr_in) begin
      masks_nxt = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_r <= alarm_pkg::FLAGS_RESET;
      masks_r <= alarm_pkg::MASKS_RESET;
    end else begin
      flags_r <= flags_nxt;
      masks_r <= masks_nxt;
    end
  end

  assign flags_out = flags_r;
  assign masks_out = masks_r;

  chk_set_wins_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (flags_wr_in && |(set_in & wdata_in)) |=> ((flags_r & $past(set_in)) == $past(set_in)))
    else $error("Alarm set lost against clear");

  chk_zero_keeps_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    flags_wr_in |=> ((flags_r & ~$past(wdata_in)) == (($past(flags_r) | $past(set_in)) & ~$past(wdata_in))))
    else $error("Writing zero changed a flag");

endmodule : alarm_regfile

// *** alarm_status_aggregator.sv ***
/*
  Alarm aggregation: five sticky alarm flags, mask bits, summary bit and
  optional routing of the summary onto the calibration status pin.
  Assumes the serial register port is decoded upstream into reg_req_t,
  one access per cycle, all inputs synchronous to clk_in.
*/
`timescale 1ns/100ps
module alarm_status_aggregator (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire alarm_pkg::reg_req_t req_in,
  input wire alarm_pkg::alarm_cond_t cond_in,
  input wire logic status_sel_alarm_in,
  input wire logic calibration_status_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic calibration_status_pin_out
);

  localparam int N = alarm_pkg::NUM_ALARMS;

  logic [N-1:0] set_vec;
  logic [N-1:0] flags;
  logic [N-1:0] masks;
  logic summary;
  logic flags_wr;
  logic masks_wr;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic pin_r, pin_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------
  // Alarm conditions
  // ----------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[alarm_pkg::PLL_UNLOCK_BIT] = ~cond_in.pll_locked;
    set_vec[alarm_pkg::LINK_DOWN_BIT] = cond_in.link_enable & ~cond_in.data_transmission_state;
    set_vec[alarm_pkg::CLOCK_REALIGN_BIT] = cond_in.sysref_realign;
    set_vec[alarm_pkg::OSC_PHASE_BIT] = ~cond_in.link_enable | cond_in.osc_sync
                                        | cond_in.phase_acc_mismatch;
    set_vec[alarm_pkg::DIVIDER_MISMATCH_BIT] = cond_in.divider_mismatch;
  end

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  assign flags_wr = req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR);
  assign masks_wr = req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR);

  alarm_regfile #(.WIDTH(N)) u_regs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(set_vec),
    .flags_wr_in(flags_wr),
    .masks_wr_in(masks_wr),
    .wdata_in(req_in.wdata[N-1:0]),
    .flags_out(flags),
    .masks_out(masks)
  );

  assign summary = |(flags & ~masks);

  // ----------------------------------------
  // Read data and status pin
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = req_in.rd;
    if (req_in.rd) begin
      rdata_nxt = 8'h00;
      if (hit(req_in.addr, alarm_pkg::ALARM_SUMMARY_ADDR)) begin
        rdata_nxt[alarm_pkg::SUMMARY_BIT] = summary;
      end else if (hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR)) begin
        rdata_nxt = {3'h0, flags};
      end else if (hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR)) begin
        rdata_nxt = {3'h0, masks};
      end
    end
    pin_nxt = status_sel_alarm_in ? summary : calibration_status_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign calibration_status_pin_out = pin_r;

  // ----------------------------------------
  // Access and alarm event sequences
  // ----------------------------------------
  sequence flags_write_seq;
    req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR);
  endsequence : flags_write_seq

  sequence masks_write_seq;
    req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR);
  endsequence : masks_write_seq

  sequence summary_read_seq;
    req_in.rd && hit(req_in.addr, alarm_pkg::ALARM_SUMMARY_ADDR);
  endsequence : summary_read_seq

  sequence flags_read_seq;
    req_in.rd && hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR);
  endsequence : flags_read_seq

  sequence masks_read_seq;
    req_in.rd && hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR);
  endsequence : masks_read_seq

  sequence unmasked_event_seq;
    |(set_vec & ~masks) && !(req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR));
  endsequence : unmasked_event_seq

  sequence idle_clear_seq;
    flags_write_seq ##0 (set_vec == '0);
  endsequence : idle_clear_seq

  sequence quiet_seq;
    (set_vec == '0) && !req_in.wr;
  endsequence : quiet_seq

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_summary_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    unmasked_event_seq |=> summary)
    else $error("Unmasked alarm did not reach summary");

  chk_pin_routing: assert property (@(posedge clk_in) disable iff (rst_in)
    status_sel_alarm_in |=> (calibration_status_pin_out == $past(summary)))
    else $error("Status pin not showing summary");

  chk_pll_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    !cond_in.pll_locked |=> flags[alarm_pkg::PLL_UNLOCK_BIT])
    else $error("PLL flag not set");

  chk_link_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (cond_in.link_enable && !cond_in.data_transmission_state) |=> flags[alarm_pkg::LINK_DOWN_BIT])
    else $error("Link flag not set");

  chk_realign_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    cond_in.sysref_realign |=> flags[alarm_pkg::CLOCK_REALIGN_BIT])
    else $error("Realign flag not set");

  chk_osc_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (!cond_in.link_enable || cond_in.osc_sync || cond_in.phase_acc_mismatch)
    |=> flags[alarm_pkg::OSC_PHASE_BIT])
    else $error("Oscillator flag not set");

  chk_divider_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    cond_in.divider_mismatch |=> flags[alarm_pkg::DIVIDER_MISMATCH_BIT])
    else $error("Divider flag not set");

  chk_reset_values: assert property (@(posedge clk_in)
    $fell(rst_in) |-> (flags == alarm_pkg::FLAGS_RESET && masks == alarm_pkg::MASKS_RESET))
    else $error("Reset values wrong");

  chk_clear_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    (req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR) && set_vec == 5'h00)
    |=> ((flags & $past(req_in.wdata[N-1:0])) == 5'h00))
    else $error("Write one did not clear flag");

  chk_mask_hides: assert property (@(posedge clk_in) disable iff (rst_in)
    (masks_write_seq ##0 (req_in.wdata[N-1:0] == alarm_pkg::MASKS_RESET)) |=> !summary)
    else $error("Masked flag reached summary");

  chk_mask_store: assert property (@(posedge clk_in) disable iff (rst_in)
    masks_write_seq |=> (masks == $past(req_in.wdata[N-1:0])))
    else $error("Mask write not stored");

  chk_masks_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !(req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_MASKS_ADDR)) |=> $stable(masks))
    else $error("Masks changed without a write");

  chk_flags_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !(req_in.wr && hit(req_in.addr, alarm_pkg::ALARM_FLAGS_ADDR))
    |=> (flags == ($past(flags) | $past(set_vec))))
    else $error("Flag changed without write or event");

  chk_summary_read: assert property (@(posedge clk_in) disable iff (rst_in)
    summary_read_seq |=> (rdata_out == {7'h00, $past(summary)}))
    else $error("Summary read data wrong");

  chk_flags_read: assert property (@(posedge clk_in) disable iff (rst_in)
    flags_read_seq |=> (rdata_out == {3'h0, $past(flags)}))
    else $error("Flag read data wrong");

  chk_masks_read: assert property (@(posedge clk_in) disable iff (rst_in)
    masks_read_seq |=> (rdata_out == {3'h0, $past(masks)}))
    else $error("Mask read data wrong");

  chk_clear_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    idle_clear_seq ##1 quiet_seq ##1 flags_read_seq
    |=> ((rdata_out[N-1:0] & $past(req_in.wdata[N-1:0], 3)) == '0))
    else $error("Cleared flag read back as set");

  chk_pin_other: assert property (@(posedge clk_in) disable iff (rst_in)
    !status_sel_alarm_in |=> (calibration_status_pin_out == $past(calibration_status_in)))
    else $error("Status pin not showing its other source");

endmodule : alarm_status_aggregator

// *** alarm_host_model.sv ***
/* Host model for the alarm register port.
   Assumes one clock shared with the block; drives on the falling edge. */
`timescale 1ns/100ps
module alarm_host_model (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output alarm_pkg::reg_req_t req_out
);
  initial req_out = '0;
  // One write, held over one rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] dat);
    @(negedge clk_in) req_out = '{1'b1, 1'b0, a, dat};
    @(negedge clk_in) req_out = '{1'b0, 1'b0, ~a, ~dat};
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] dat, output logic ok);
    @(negedge clk_in) req_out = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in) req_out = '{1'b0, 1'b0, ~a, 8'hFF};
    ok = rvalid_in;
    dat = rdata_in;
  endtask : rd
endmodule : alarm_host_model

// *** alarm_status_aggregator_tb_top.sv ***
/* Self-checking testbench for the alarm aggregator.
   Assumes the host model and the design package are compiled first. */
`timescale 1ns/100ps
module alarm_status_aggregator_tb_top;
  localparam logic [11:0] FA = alarm_pkg::ALARM_FLAGS_ADDR;
  localparam logic [11:0] MA = alarm_pkg::ALARM_MASKS_ADDR;
  localparam logic [11:0] SA = alarm_pkg::ALARM_SUMMARY_ADDR;
  localparam logic [6:0] CONDS [7] = '{7'h30, 7'h60, 7'h78, 7'h74, 7'h72, 7'h50, 7'h71};
  localparam logic [7:0] EXPS [7] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h02, 8'h02, 8'h01};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  alarm_pkg::reg_req_t req;
  alarm_pkg::alarm_cond_t cond = 7'h70;
  logic sel = 1'b0;
  logic cal = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic pin;
  logic [7:0] d;
  logic v;
  int n_errors = 0;
  int num_checks = 0;
  initial forever #50 clk_in = ~clk_in;
  alarm_host_model i_alarm_host_model (.clk_in(clk_in), .rvalid_in(rvalid), .rdata_in(rdata), .req_out(req));
  alarm_status_aggregator i_alarm_status_aggregator (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .cond_in(cond), .status_sel_alarm_in(sel), .calibration_status_in(cal), .rdata_out(rdata),
    .rvalid_out(rvalid), .calibration_status_pin_out(pin));
  // ---
  // Compare and access helpers
  // ---
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t byte %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    i_alarm_host_model.rd(a, d, v);
    chk1(v, 1'b1);
    chk8(d, e);
  endtask : rdchk
  task automatic t_reset;
    rdchk(FA, 8'h1F);
    rdchk(MA, 8'h1F);
    rdchk(SA, 8'h00);
    rdchk(12'h2C3, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_clear;
    i_alarm_host_model.wr(FA, 8'h00);
    rdchk(FA, 8'h1F);
    i_alarm_host_model.wr(FA, 8'h05);
    rdchk(FA, 8'h1A);
    i_alarm_host_model.wr(FA, 8'hFF);
    rdchk(FA, 8'h00);
    $display("test clear done");
  endtask : t_clear
  task automatic t_sources;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_in) cond = CONDS[i];
      @(negedge clk_in) cond = 7'h70;
      rdchk(FA, EXPS[i]);
      i_alarm_host_model.wr(FA, 8'h1F);
    end
    $display("test sources done");
  endtask : t_sources
  task automatic t_mask_pin;
    @(negedge clk_in) cond = 7'h30;
    i_alarm_host_model.wr(FA, 8'h1F);
    rdchk(FA, 8'h10);
    i_alarm_host_model.wr(MA, 8'hEF);
    rdchk(MA, 8'h0F);
    rdchk(SA, 8'h01);
    @(negedge clk_in) sel = 1'b1;
    @(negedge clk_in) chk1(pin, 1'b1);
    i_alarm_host_model.wr(MA, 8'h1F);
    rdchk(SA, 8'h00);
    chk1(pin, 1'b0);
    @(negedge clk_in) sel = 1'b0;
    cal = 1'b1;
    @(negedge clk_in) chk1(pin, 1'b1);
    cond = 7'h70;
    $display("test mask and pin done");
  endtask : t_mask_pin
  task automatic t_rereset;
    i_alarm_host_model.wr(MA, 8'h00);
    rdchk(SA, 8'h01);
    i_alarm_host_model.wr(FA, 8'h1F);
    rdchk(SA, 8'h00);
    @(negedge clk_in) rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    rdchk(FA, 8'h1F);
    rdchk(MA, 8'h1F);
    rdchk(SA, 8'h00);
    $display("test second reset done");
  endtask : t_rereset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_clear();
    t_sources();
    t_mask_pin();
    t_rereset();
    finish_test();
  end
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
endmodule : alarm_status_aggregator_tb_top
